// File: common/fwpc_pkg.sv
// Purpose: Shared constants and types for the flash write-protect command decoder.
// Assumes: A single system clock; SPI pins arrive asynchronously.
// Notes:   Opcodes are eight bits and are shifted most significant bit first.
package fwpc_pkg;

    localparam logic [7:0]  OP_WRITE_ENABLE    = 8'h06;
    localparam logic [7:0]  OP_WRITE_DISABLE   = 8'h04;
    localparam logic [7:0]  OP_VOLATILE_WREN   = 8'h50;
    localparam logic [7:0]  OP_BLOCK_LOCK      = 8'h36;
    localparam logic [7:0]  OP_BLOCK_UNLOCK    = 8'h39;
    localparam logic [7:0]  OP_WRITE_STATUS    = 8'h01;

    localparam int          ADDR_W             = 24;
    localparam int          BLOCK_LSB          = 12;
    localparam int          BLOCK_W            = 10;
    localparam int          NUM_BLOCKS         = 1024;
    localparam int          CNT_W              = 6;

    localparam logic [5:0]  BITS_OPCODE        = 6'h08;
    localparam logic [5:0]  BITS_WITH_ADDR     = 6'h20;
    localparam logic [5:0]  BITS_SATURATE      = 6'h3F;
    localparam logic [2:0]  BYTE_ALIGNED       = 3'h0;

    localparam logic        LOCK_RESET_VALUE   = 1'b1;
    localparam logic        WEL_RESET_VALUE    = 1'b0;

    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic si;
    } fwpc_spi_t;

endpackage : fwpc_pkg

// File: hdl/fwpc_core.sv
// Purpose: Serial command decoder for write disable, volatile status enable and per-block lock and unlock.
// Assumes: clk_sys_in runs well above the serial clock so every serial edge is seen after synchronising.
// Notes:   Lock bits cover 4 kB regions of a 4 MB array and live in flip-flops.
`timescale 1ns/100ps

// Summary of operation
// - Write-disable opcode then chip select high clears the write-enable latch.
// - With the latch clear, program and erase are refused, and status writes too unless volatile write enable armed them.
// - Opcodes arrive as eight serial bits, most significant first.
// - Write disable and volatile write enable carry no address or data.
// - Chip select high off a byte boundary aborts; nothing changes.
// - Volatile write enable leaves the write-enable latch untouched.
// - The volatile permission covers only the next status write, then expires.
// - Block lock is opcode plus 24 address bits, bit 23 first.
// - Block unlock is opcode plus 24 address bits, bit 23 first.
// - On commit, lock or unlock the block and clear the latch in the same cycle.
// - Lock and unlock act only if write enable set the latch.
// - Lock bits apply when protect select is set, otherwise range bits decide.
// - All lock bits are one after reset.
// - Program and erase to a locked block are refused while protect select is set.
// - Each lock bit covers the aligned 4 kB region holding the address.
// - Write-enable opcode then chip select high sets the latch.
module fwpc_core
(
    input  wire logic                      clk_sys_in,
    input  wire logic                      reset_in,
    input  wire fwpc_pkg::fwpc_spi_t       spi_in,
    input  wire logic                      block_protect_select_in,
    input  wire logic                      range_allows_in,
    input  wire logic [fwpc_pkg::ADDR_W-1:0] target_addr_in,
    output logic                           write_enable_latch_out,
    output logic                           volatile_armed_out,
    output logic                           status_write_permit_out,
    output logic                           prog_erase_permit_out
);

    logic [2:0]                   sync1_q;
    logic [2:0]                   sync2_q;
    logic                         sclk_prev_q;
    logic                         cs_prev_q;
    logic [fwpc_pkg::CNT_W-1:0]   bit_cnt_q;
    logic [fwpc_pkg::ADDR_W-1:0]  shift_q;
    logic [7:0]                   opcode_q;
    logic [fwpc_pkg::ADDR_W-1:0]  addr_q;
    logic                         wel_q;
    logic                         armed_q;
    logic                         sw_permit_q;
    logic                         pe_permit_q;
    logic [fwpc_pkg::NUM_BLOCKS-1:0] lock_q;
    logic                         cs_n_s;
    logic                         sclk_s;
    logic                         si_s;
    logic                         sample_edge;
    logic                         cs_rise;
    logic                         commit;
    logic                         lock_cmd_ok;
    logic [fwpc_pkg::BLOCK_W-1:0] cmd_block;

    // Picks the 4 kB region that holds an address.
    function automatic logic [fwpc_pkg::BLOCK_W-1:0] block_of(input logic [fwpc_pkg::ADDR_W-1:0] a);
        block_of = a[fwpc_pkg::BLOCK_LSB +: fwpc_pkg::BLOCK_W];
    endfunction : block_of

    // Only the second stage is read, so metastability never reaches the decode.
    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            sync1_q <= 3'h7;
            sync2_q <= 3'h7;
        end
        else
        begin
            sync1_q <= {spi_in.cs_n, spi_in.sclk, spi_in.si};
            sync2_q <= sync1_q;
        end
    end

    assign cs_n_s      = sync2_q[2];
    assign sclk_s      = sync2_q[1];
    assign si_s        = sync2_q[0];
    assign sample_edge = !cs_n_s && sclk_s && !sclk_prev_q;
    assign cs_rise     = cs_n_s && !cs_prev_q;
    // Commands end only on a byte boundary after at least the opcode.
    assign commit      = cs_rise && (bit_cnt_q[2:0] == fwpc_pkg::BYTE_ALIGNED)
                         && (bit_cnt_q >= fwpc_pkg::BITS_OPCODE);
    assign lock_cmd_ok = commit && wel_q && (bit_cnt_q >= fwpc_pkg::BITS_WITH_ADDR)
                         && ((opcode_q == fwpc_pkg::OP_BLOCK_LOCK) || (opcode_q == fwpc_pkg::OP_BLOCK_UNLOCK));
    assign cmd_block   = block_of(addr_q);

    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            sclk_prev_q <= 1'b1;
            cs_prev_q   <= 1'b1;
        end
        else
        begin
            sclk_prev_q <= sclk_s;
            cs_prev_q   <= cs_n_s;
        end
    end

    // Bit counter and shifter; at its top the counter steps back to a byte boundary above the address phase.
    // This keeps long bursts byte aligned without letting the opcode or address capture fire again.
    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            bit_cnt_q <= '0;
            shift_q   <= '0;
        end
        else if (cs_n_s)
        begin
            bit_cnt_q <= '0;
        end
        else if (sample_edge)
        begin
            shift_q <= {shift_q[fwpc_pkg::ADDR_W-2:0], si_s};
            if (bit_cnt_q == fwpc_pkg::BITS_SATURATE)
            begin
                bit_cnt_q <= fwpc_pkg::BITS_SATURATE - 6'h07;
            end
            else
            begin
                bit_cnt_q <= bit_cnt_q + 6'h01;
            end
        end
    end

    // Opcode is caught after eight bits, address after the following 24.
    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            opcode_q <= 8'h00;
            addr_q   <= '0;
        end
        else if (!sample_edge && !cs_n_s)
        begin
            if (bit_cnt_q == fwpc_pkg::BITS_OPCODE && cs_prev_q == 1'b0 && sclk_prev_q)
            begin
                opcode_q <= shift_q[7:0];
            end
            if (bit_cnt_q == fwpc_pkg::BITS_WITH_ADDR && sclk_prev_q)
            begin
                addr_q <= shift_q[23:0];
            end
        end
    end

    // Write-enable latch; opcode-only commands need no more than their eight bits.
    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            wel_q <= fwpc_pkg::WEL_RESET_VALUE;
        end
        else if (commit)
        begin
            if (opcode_q == fwpc_pkg::OP_WRITE_ENABLE)
            begin
                wel_q <= 1'b1;
            end
            else if (opcode_q == fwpc_pkg::OP_WRITE_DISABLE)
            begin
                wel_q <= 1'b0;
            end
            else if (lock_cmd_ok)
            begin
                wel_q <= 1'b0;
            end
        end
    end

    // Volatile permission: armed by its opcode, spent by the next status write.
    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            armed_q <= 1'b0;
        end
        else if (commit && opcode_q == fwpc_pkg::OP_VOLATILE_WREN)
        begin
            armed_q <= 1'b1;
        end
        else if (commit && opcode_q == fwpc_pkg::OP_WRITE_STATUS)
        begin
            armed_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            lock_q <= {fwpc_pkg::NUM_BLOCKS{fwpc_pkg::LOCK_RESET_VALUE}};
        end
        else if (lock_cmd_ok)
        begin
            lock_q[cmd_block] <= (opcode_q == fwpc_pkg::OP_BLOCK_LOCK);
        end
    end

    // Permits are registered, so they trail a latch or lock change by one cycle.
    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            sw_permit_q <= 1'b0;
            pe_permit_q <= 1'b0;
        end
        else
        begin
            sw_permit_q <= wel_q || armed_q;
            pe_permit_q <= wel_q && (block_protect_select_in ? !lock_q[block_of(target_addr_in)]
                                                             : range_allows_in);
        end
    end

    assign write_enable_latch_out  = wel_q;
    assign volatile_armed_out      = armed_q;
    assign status_write_permit_out = sw_permit_q;
    assign prog_erase_permit_out   = pe_permit_q;

    property p_wdis;
        @(posedge clk_sys_in) disable iff (reset_in)
        commit && opcode_q == fwpc_pkg::OP_WRITE_DISABLE |=> !wel_q;
    endproperty
    a_wdis: assert property (p_wdis) else $error("Latch not cleared by write disable.");

    property p_wren;
        @(posedge clk_sys_in) disable iff (reset_in)
        commit && opcode_q == fwpc_pkg::OP_WRITE_ENABLE |=> wel_q ##1 sw_permit_q;
    endproperty
    a_wren: assert property (p_wren) else $error("Latch or permit not set by write enable.");

    property p_vwren;
        @(posedge clk_sys_in) disable iff (reset_in)
        commit && opcode_q == fwpc_pkg::OP_VOLATILE_WREN |=> $stable(wel_q) && armed_q;
    endproperty
    a_vwren: assert property (p_vwren) else $error("Volatile enable misbehaved.");

    property p_expire;
        @(posedge clk_sys_in) disable iff (reset_in)
        commit && opcode_q == fwpc_pkg::OP_WRITE_STATUS |=> !armed_q;
    endproperty
    a_expire: assert property (p_expire) else $error("Volatile permission outlived status write.");

    property p_abort;
        @(posedge clk_sys_in) disable iff (reset_in)
        cs_rise && bit_cnt_q[2:0] != fwpc_pkg::BYTE_ALIGNED |=> $stable(wel_q) && $stable(armed_q) && $stable(lock_q);
    endproperty
    a_abort: assert property (p_abort) else $error("Misaligned command changed state.");

    property p_lock;
        @(posedge clk_sys_in) disable iff (reset_in)
        lock_cmd_ok |=> !wel_q && lock_q[$past(cmd_block)] == ($past(opcode_q) == fwpc_pkg::OP_BLOCK_LOCK);
    endproperty
    a_lock: assert property (p_lock) else $error("Block lock update wrong.");

    property p_nowel;
        @(posedge clk_sys_in) disable iff (reset_in)
        commit && !wel_q |=> $stable(lock_q);
    endproperty
    a_nowel: assert property (p_nowel) else $error("Lock changed without latch set.");

    property p_count;
        @(posedge clk_sys_in) disable iff (reset_in)
        sample_edge && bit_cnt_q < 6'h3E |=> bit_cnt_q == $past(bit_cnt_q) + 6'h01;
    endproperty
    a_count: assert property (p_count) else $error("Bit count did not advance.");

    property p_protect;
        @(posedge clk_sys_in) disable iff (reset_in)
        !wel_q ##1 1'b1 |-> !prog_erase_permit_out;
    endproperty
    a_protect: assert property (p_protect) else $error("Program permitted without latch.");

    property p_range;
        @(posedge clk_sys_in) disable iff (reset_in)
        wel_q && !block_protect_select_in |=> prog_erase_permit_out == $past(range_allows_in);
    endproperty
    a_range: assert property (p_range) else $error("Range bits ignored without protect select.");

endmodule : fwpc_core

// File: testbench/fwpc_host_model.sv
// Purpose: SPI host model that shifts commands into the decoder.
// Assumes: Mode 3 timing with four system clocks per serial phase.
// Notes:   Serial clock stands high between frames.
`timescale 1ns/100ps
module fwpc_host_model
(
    input  wire logic          clk_sys_in,
    output fwpc_pkg::fwpc_spi_t spi_out
);
    initial spi_out = '{cs_n: 1'b1, sclk: 1'b1, si: 1'b0};
    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk_sys_in);
    endtask : wait_clk
    // Shifts the top n bits of word, then releases select.
    task automatic send(input logic [31:0] word, input int n);
        spi_out.cs_n = 1'b0;
        wait_clk(4);
        for (int i = 0; i < n; i++)
        begin
            spi_out.sclk = 1'b0;
            spi_out.si   = word[31 - i];
            wait_clk(4);
            spi_out.sclk = 1'b1;
            wait_clk(4);
        end
        spi_out.cs_n = 1'b1;
        // A released line must not keep showing the last bit.
        spi_out.si   = ~spi_out.si;
        wait_clk(8);
    endtask : send
endmodule : fwpc_host_model

// File: testbench/tb_top.sv
// Purpose: Self-checking bench for the write-protect command decoder.
// Assumes: Inputs change on falling clock edges.
// Notes:   Rows carry state forward, so their order matters.
`timescale 1ns/100ps
module tb_top;
    typedef struct {
        logic [31:0] cmd;
        int          nbits;
        logic        sel;
        logic        rng;
        logic [23:0] addr;
        logic [3:0]  exp;
    } fwpc_row_t;
    logic                clk_sys_in;
    logic                reset_in;
    logic                block_protect_select_in;
    logic                range_allows_in;
    logic [23:0]         target_addr_in;
    fwpc_pkg::fwpc_spi_t spi;
    wire logic [3:0]     got;
    fwpc_row_t           rows[$];
    int                  err_count;
    int                  n_compared;

    fwpc_host_model HOST (.clk_sys_in(clk_sys_in), .spi_out(spi));
    fwpc_core DUT
    (
        .clk_sys_in              (clk_sys_in),
        .reset_in                (reset_in),
        .spi_in                  (spi),
        .block_protect_select_in (block_protect_select_in),
        .range_allows_in         (range_allows_in),
        .target_addr_in          (target_addr_in),
        .write_enable_latch_out  (got[3]),
        .volatile_armed_out      (got[2]),
        .status_write_permit_out (got[1]),
        .prog_erase_permit_out   (got[0])
    );

    initial
    begin
        clk_sys_in = 1'b0;
        forever #50 clk_sys_in = ~clk_sys_in;
    end

    task automatic print_verdict;
        $display("Compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : print_verdict

    // Expected nibble is latch, armed, status permit, program permit.
    task automatic chk(input logic [3:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic add(input logic [31:0] c, input int n, input logic s, input logic r,
                       input logic [23:0] a, input logic [3:0] e);
        rows.push_back('{c, n, s, r, a, e});
    endtask : add

    task automatic run(input fwpc_row_t r);
        block_protect_select_in = r.sel;
        range_allows_in         = r.rng;
        target_addr_in          = r.addr;
        HOST.send(r.cmd, r.nbits);
        chk(r.exp);
    endtask : run

    // Every wait is a fixed count, so a cut-off here only guards a stuck simulator.
    initial
    begin
        #5000000;
        err_count++;
        print_verdict();
    end

    initial
    begin
        err_count               = 0;
        n_compared              = 0;
        reset_in                = 1'b1;
        block_protect_select_in = 1'b0;
        range_allows_in         = 1'b0;
        target_addr_in          = 24'h000000;
        add(32'h06000000, 8, 1'b1, 1'b0, 24'h001234, 4'hA);
        add(32'h39001234, 32, 1'b1, 1'b0, 24'h001234, 4'h0);
        add(32'h06000000, 8, 1'b1, 1'b0, 24'h001FFF, 4'hB);
        add(32'h06000000, 8, 1'b1, 1'b0, 24'h000FFF, 4'hA);
        add(32'h06000000, 8, 1'b1, 1'b0, 24'h002000, 4'hA);
        add(32'h50000000, 8, 1'b0, 1'b1, 24'h002000, 4'hF);
        add(32'h01000000, 8, 1'b0, 1'b0, 24'h002000, 4'hA);
        add(32'h04000000, 8, 1'b1, 1'b0, 24'h001000, 4'h0);
        add(32'h50000000, 8, 1'b1, 1'b0, 24'h001000, 4'h6);
        add(32'h01000000, 8, 1'b1, 1'b0, 24'h001000, 4'h0);
        add(32'h36001ABC, 32, 1'b1, 1'b0, 24'h001000, 4'h0);
        add(32'h06000000, 8, 1'b1, 1'b0, 24'h001000, 4'hB);
        add(32'h36001ABC, 32, 1'b1, 1'b0, 24'h001000, 4'h0);
        add(32'h06000000, 8, 1'b1, 1'b0, 24'h001000, 4'hA);
        repeat (2) @(negedge clk_sys_in);
        reset_in = 1'b0;
        HOST.wait_clk(4);
        chk(4'h0);
        foreach (rows[i])
            run(rows[i]);
        // Three frames aborted off a byte boundary or ended before the address is complete must leave everything as it was; a full unlock follows.
        run('{32'h04000000, 7, 1'b1, 1'b0, 24'h001000, 4'hA});
        run('{32'h39001000, 12, 1'b1, 1'b0, 24'h001000, 4'hA});
        run('{32'h39001000, 24, 1'b1, 1'b0, 24'h001000, 4'hA});
        run('{32'h39001000, 32, 1'b1, 1'b0, 24'h001000, 4'h0});
        run('{32'h06000000, 8, 1'b1, 1'b0, 24'h001FFF, 4'hB});
        // A second reset in mid-run must lock the block again.
        reset_in = 1'b1;
        HOST.wait_clk(2);
        chk(4'h0);
        reset_in = 1'b0;
        HOST.wait_clk(4);
        run('{32'h06000000, 8, 1'b1, 1'b0, 24'h001FFF, 4'hA});
        print_verdict();
    end
endmodule : tb_top
